//--- src/aoff_pkg.sv
// Constants, field layout and types shared by the output frame formatter files
//
// Notes on behaviour
// [R1] Own 4-bit device address is appended to the frame when bit 14 is set.
// [R2] Bits 13-12 pick supply flags appended: none, high, low, or both.
// [R3] Bits 11-10 pick input flags appended: none, high, low, or both.
// [R4] Bit 8 set appends the 4-bit input span code to the frame.
// [R5] Bit 3 set appends two parity bits at the end, two bits longer.
// [R6] First parity bit is even parity over the value field bits only.
// [R7] Second parity bit is even parity over the whole frame content.
// [R8] The value parity bit is left out of the whole-frame parity.
// [R9] Bit 3 clear sends the frame with no parity bits at all.
// [R10] Bits 2-0 pick value field: sample, zeros, ones, 0101 or 0011 patterns.
// [R11] Reserved output configuration bits always read back as zero.
// [R12] Span and reference register sits at byte 14h, low byte lowest.
// [R13] Span code resets on power-on only; reference-off bit on either reset.
// [R14] Plain-reset configuration fields return to default on application reset too.
// [R15] Span code selects bipolar codes 0000-0100 or unipolar codes 1000-1011.
// [R16] Reference-off bit zero keeps on-chip reference on, one turns it off.
// [R17] Each appended alarm flag is one while its condition exists now.
// [R18] Value field goes first, MSB first, optional fields fixed order, parity last.
package aoff_pkg;
    localparam int unsigned SAMPLE_W = 16;
    localparam int unsigned FRAME_W = 32;
    localparam int unsigned LEN_W = 6;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned WORD_W = FRAME_W + LEN_W;
    localparam int unsigned BUF_DEPTH = 2;

    localparam logic [ADDR_W-1:0] OFS_FRAME_CFG = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_SPAN_CFG = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;

    localparam int unsigned BIT_OWN_ID = 14;
    localparam int unsigned SUPPLY_LSB = 12;
    localparam int unsigned INPUT_LSB = 10;
    localparam int unsigned BIT_SPAN_APPEND = 8;
    localparam int unsigned BIT_PARITY = 3;
    localparam int unsigned PATTERN_LSB = 0;
    localparam int unsigned BIT_REF_OFF = 6;
    localparam int unsigned SPAN_LSB = 0;
    localparam int unsigned BIT_ST_BUSY = 0;
    localparam int unsigned ST_COUNT_LSB = 1;

    localparam logic [DATA_W-1:0] FRAME_CFG_MASK = 32'h0000_7d0f;
    localparam logic [DATA_W-1:0] FRAME_CFG_RST = 32'h0000_0000;
    localparam logic [3:0] SPAN_CODE_RST = 4'h0;
    localparam logic REF_OFF_RST = 1'b0;

    localparam logic [2:0] PAT_CODE_ZEROS = 3'h4;
    localparam logic [2:0] PAT_CODE_ONES = 3'h5;
    localparam logic [2:0] PAT_CODE_ALT1 = 3'h6;
    localparam logic [2:0] PAT_CODE_ALT2 = 3'h7;
    localparam logic [SAMPLE_W-1:0] PAT_ZEROS = 16'h0000;
    localparam logic [SAMPLE_W-1:0] PAT_ONES = 16'hffff;
    localparam logic [SAMPLE_W-1:0] PAT_ALT1 = 16'h5555;
    localparam logic [SAMPLE_W-1:0] PAT_ALT2 = 16'h3333;

    localparam logic [3:0] SPAN_BIPOLAR_MAX = 4'h4;
    localparam logic [3:0] SPAN_UNIPOLAR_MIN = 4'h8;
    localparam logic [3:0] SPAN_UNIPOLAR_MAX = 4'hb;

    localparam logic [2:0] ID_W = 3'h4;
    localparam logic [2:0] SPAN_W = 3'h4;
    localparam logic [2:0] PARITY_W = 3'h2;

    typedef enum logic [1:0] {
        st_idle = 2'b01,
        st_shift = 2'b10
    } aoff_shift_state_type;
endpackage

//--- src/aoff_word_if.sv
// Frame word channel between the formatter, its buffer and the serializer
`timescale 1ns/1ps
`default_nettype none
interface aoff_word_if #(parameter int unsigned W = 38);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- src/aoff_frame_buf.sv
// Small FIFO that holds composed frames while the serializer is stalled
`timescale 1ns/1ps
`default_nettype none
module aoff_frame_buf import aoff_pkg::*; #(
    parameter int unsigned WIDTH = WORD_W,
    parameter int unsigned DEPTH = BUF_DEPTH
) (
    input wire logic i_clock,
    input wire logic i_reset,
    aoff_word_if.sink up,
    aoff_word_if.source down,
    output logic [$clog2(DEPTH+1)-1:0] o_count
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);

    if (DEPTH < 2) begin : g_chk_depth
        $error("aoff_frame_buf: DEPTH must be at least 2");
    end
    if ($bits(up.data) != WIDTH || $bits(down.data) != WIDTH) begin : g_chk_width
        $error("aoff_frame_buf: WIDTH does not match the channel");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [CW-1:0] count_q;
    logic push;
    logic pop;

    function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    assign up.ready = (count_q != CW'(DEPTH));
    assign down.valid = (count_q != '0);
    assign down.data = mem_q[rd_q];
    assign push = up.valid && up.ready;
    assign pop = down.valid && down.ready;
    assign o_count = count_q;

    always_ff @(posedge i_clock) begin
        if (push) begin
            mem_q[wr_q] <= up.data;
        end
    end

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_q <= ptr_next(wr_q);
            end
            if (pop) begin
                rd_q <= ptr_next(rd_q);
            end
            if (push && !pop) begin
                count_q <= count_q + CW'(1);
            end else if (pop && !push) begin
                count_q <= count_q - CW'(1);
            end
        end
    end
endmodule // aoff_frame_buf
`default_nettype wire

//--- src/aoff_frame_shifter.sv
// Shifts one frame word out bit by bit, most significant bit first
`timescale 1ns/1ps
`default_nettype none
module aoff_frame_shifter import aoff_pkg::*; (
    input wire logic i_clock,
    input wire logic i_reset,
    aoff_word_if.sink frame,
    output logic o_bit,
    output logic o_bit_valid,
    input wire logic i_bit_ready,
    output logic o_last,
    output logic o_busy
);
    aoff_shift_state_type state_q;
    logic [FRAME_W-1:0] sh_q;
    logic [LEN_W-1:0] left_q;
    logic [FRAME_W-1:0] load_frame;
    logic [LEN_W-1:0] load_len;

    assign load_frame = frame.data[FRAME_W-1:0];
    assign load_len = frame.data[WORD_W-1:FRAME_W];
    // A new word is taken only between frames, so a frame is never cut short
    assign frame.ready = (state_q == st_idle);
    assign o_bit = sh_q[FRAME_W-1];
    assign o_bit_valid = (state_q == st_shift);
    assign o_last = (state_q == st_shift) && (left_q == LEN_W'(1));
    assign o_busy = (state_q == st_shift);

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            state_q <= st_idle;
            sh_q <= '0;
            left_q <= '0;
        end else begin
            case (state_q)
                st_idle: begin
                    if (frame.valid) begin
                        // Left-justify so the first field leaves first
                        sh_q <= load_frame << (LEN_W'(FRAME_W) - load_len); // R18
                        left_q <= load_len;
                        state_q <= st_shift;
                    end
                end
                st_shift: begin
                    if (i_bit_ready) begin
                        sh_q <= {sh_q[FRAME_W-2:0], 1'b0};
                        left_q <= left_q - LEN_W'(1);
                        if (left_q == LEN_W'(1)) begin
                            state_q <= st_idle;
                        end
                    end
                end
                default: begin
                    state_q <= st_idle;
                end
            endcase
        end
    end
endmodule // aoff_frame_shifter
`default_nettype wire

//--- src/aoff_frame_formatter.sv
// Output frame formatter: configuration registers, frame composition and output path
`timescale 1ns/1ps
`default_nettype none
module aoff_frame_formatter import aoff_pkg::*; (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_app_reset,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    output logic [DATA_W-1:0] o_rdata,
    input wire logic [SAMPLE_W-1:0] i_sample,
    input wire logic i_sample_valid,
    output logic o_sample_ready,
    input wire logic [3:0] i_device_addr,
    input wire logic i_supply_hi,
    input wire logic i_supply_lo,
    input wire logic i_input_hi,
    input wire logic i_input_lo,
    output logic o_serial_out,
    output logic o_bit_valid,
    input wire logic i_bit_ready,
    output logic o_frame_last,
    output logic o_frame_active,
    output logic [3:0] o_span_code,
    output logic o_span_unipolar,
    output logic o_span_code_valid,
    output logic o_onchip_reference_off
);
    localparam int unsigned CNT_W = $clog2(BUF_DEPTH + 1);

    logic [DATA_W-1:0] frame_cfg_q;
    logic [3:0] span_code_q;
    logic ref_off_q;
    logic [DATA_W-1:0] rdata_q;
    logic [CNT_W-1:0] buf_count;
    logic shifter_busy;

    logic [SAMPLE_W-1:0] value_field;
    logic [FRAME_W-1:0] frame_word;
    logic [LEN_W-1:0] frame_len;
    logic value_par;
    logic frame_par;

    aoff_word_if #(.W(WORD_W)) push_ch ();
    aoff_word_if #(.W(WORD_W)) pop_ch ();

    function automatic logic [FRAME_W-1:0] frame_push(input logic [FRAME_W-1:0] f, input logic [3:0] bits,
                                                      input logic [2:0] n);
        logic [4:0] m;
        m = (5'h01 << n) - 5'h01;
        return (f << n) | FRAME_W'(bits & m[3:0]);
    endfunction

    // Flags go out high first, then low, when both are picked
    function automatic logic [3:0] flag_bits(input logic [1:0] sel, input logic hi, input logic lo);
        case (sel)
            2'b01: return {3'h0, hi};
            2'b10: return {3'h0, lo};
            2'b11: return {2'h0, hi, lo};
            default: return 4'h0;
        endcase
    endfunction

    function automatic logic [2:0] flag_count(input logic [1:0] sel);
        return 3'(sel[1]) + 3'(sel[0]);
    endfunction

    // Output configuration register: fields return to default on either reset
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            frame_cfg_q <= FRAME_CFG_RST;
        end else if (i_app_reset) begin
            frame_cfg_q <= FRAME_CFG_RST; // R14
        end else if (i_write && i_addr == OFS_FRAME_CFG) begin
            frame_cfg_q <= i_wdata & FRAME_CFG_MASK; // R11
        end
    end

    // Span code survives an application reset so a running range is not lost
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            span_code_q <= SPAN_CODE_RST; // R13
        end else if (i_write && i_addr == OFS_SPAN_CFG) begin
            span_code_q <= i_wdata[SPAN_LSB +: 4]; // R12
        end
    end

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            ref_off_q <= REF_OFF_RST;
        end else if (i_app_reset) begin
            ref_off_q <= REF_OFF_RST; // R13
        end else if (i_write && i_addr == OFS_SPAN_CFG) begin
            ref_off_q <= i_wdata[BIT_REF_OFF];
        end
    end

    // Read data stand only in the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            rdata_q <= '0;
        end else if (!i_read) begin
            rdata_q <= '0;
        end else if (i_addr == OFS_FRAME_CFG) begin
            rdata_q <= frame_cfg_q; // R11
        end else if (i_addr == OFS_SPAN_CFG) begin
            rdata_q <= DATA_W'({ref_off_q, 2'h0, span_code_q}); // R12
        end else if (i_addr == OFS_STATUS) begin
            rdata_q <= DATA_W'({buf_count, shifter_busy});
        end else begin
            rdata_q <= '0;
        end
    end

    assign o_rdata = rdata_q;
    assign o_span_code = span_code_q;
    assign o_span_unipolar = span_code_q[3]; // R15
    assign o_span_code_valid = (span_code_q <= SPAN_BIPOLAR_MAX) ||
                               (span_code_q >= SPAN_UNIPOLAR_MIN && span_code_q <= SPAN_UNIPOLAR_MAX); // R15
    assign o_onchip_reference_off = ref_off_q; // R16

    always_comb begin
        case (frame_cfg_q[PATTERN_LSB +: 3])
            PAT_CODE_ZEROS: value_field = PAT_ZEROS; // R10
            PAT_CODE_ONES: value_field = PAT_ONES; // R10
            PAT_CODE_ALT1: value_field = PAT_ALT1; // R10
            PAT_CODE_ALT2: value_field = PAT_ALT2; // R10
            default: value_field = i_sample; // R10
        endcase
    end

    // Fields are sampled as the word enters the buffer, so flags are current then
    always_comb begin
        frame_word = FRAME_W'(value_field); // R18
        frame_len = LEN_W'(SAMPLE_W);
        if (frame_cfg_q[BIT_OWN_ID]) begin
            frame_word = frame_push(frame_word, i_device_addr, ID_W); // R1
            frame_len = frame_len + LEN_W'(ID_W);
        end
        frame_word = frame_push(frame_word, flag_bits(frame_cfg_q[SUPPLY_LSB +: 2], i_supply_hi, i_supply_lo),
                                flag_count(frame_cfg_q[SUPPLY_LSB +: 2])); // R2 R17
        frame_len = frame_len + LEN_W'(flag_count(frame_cfg_q[SUPPLY_LSB +: 2]));
        frame_word = frame_push(frame_word, flag_bits(frame_cfg_q[INPUT_LSB +: 2], i_input_hi, i_input_lo),
                                flag_count(frame_cfg_q[INPUT_LSB +: 2])); // R3 R17
        frame_len = frame_len + LEN_W'(flag_count(frame_cfg_q[INPUT_LSB +: 2]));
        if (frame_cfg_q[BIT_SPAN_APPEND]) begin
            frame_word = frame_push(frame_word, span_code_q, SPAN_W); // R4
            frame_len = frame_len + LEN_W'(SPAN_W);
        end
        value_par = ^value_field; // R6
        frame_par = ^frame_word; // R7 R8
        if (frame_cfg_q[BIT_PARITY]) begin
            frame_word = frame_push(frame_word, {2'h0, value_par, frame_par}, PARITY_W); // R5
            frame_len = frame_len + LEN_W'(PARITY_W);
        end // R9
    end

    // A full buffer holds the sample source off instead of dropping a frame
    assign push_ch.valid = i_sample_valid;
    assign push_ch.data = {frame_len, frame_word};
    assign o_sample_ready = push_ch.ready;

    aoff_frame_buf #(.WIDTH(WORD_W), .DEPTH(BUF_DEPTH)) u_buf (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .up(push_ch.sink),
        .down(pop_ch.source),
        .o_count(buf_count)
    );

    aoff_frame_shifter u_shift (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .frame(pop_ch.sink),
        .o_bit(o_serial_out),
        .o_bit_valid(o_bit_valid),
        .i_bit_ready(i_bit_ready),
        .o_last(o_frame_last),
        .o_busy(shifter_busy)
    );

    assign o_frame_active = shifter_busy;
endmodule // aoff_frame_formatter
`default_nettype wire

//--- test/aoff_frame_formatter_checker.sv
// Port-level assertions for the output frame formatter
`timescale 1ns/1ps
`default_nettype none
module aoff_frame_formatter_checker (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_app_reset,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    input wire logic [31:0] o_rdata,
    input wire logic o_bit_valid,
    input wire logic i_bit_ready,
    input wire logic o_serial_out,
    input wire logic o_frame_last,
    input wire logic [3:0] o_span_code,
    input wire logic o_span_code_valid,
    input wire logic o_onchip_reference_off
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    rd_idle_a: assert property (!$past(i_read) |-> o_rdata == 32'h0)
        else $error("read data not zero outside read cycle");
    cfg_rsvd_a: assert property ($past(i_read) && $past(i_addr) == 8'h10 |-> (o_rdata & 32'hffff82f0) == 32'h0)
        else $error("reserved frame config bit read as one");
    span_rsvd_a: assert property ($past(i_read) && $past(i_addr) == 8'h14 |-> (o_rdata & 32'hffffffb0) == 32'h0)
        else $error("reserved span config bit read as one");
    span_wr_a: assert property (i_write && i_addr == 8'h14 |=> {28'h0, o_span_code} == ($past(i_wdata) & 32'hf))
        else $error("span code write not taken");
    ref_wr_a: assert property (i_write && i_addr == 8'h14 && !i_app_reset
        |=> {25'h0, o_onchip_reference_off, 6'h0} == ($past(i_wdata) & 32'h40))
        else $error("reference off write not taken");
    app_ref_a: assert property (i_app_reset |=> !o_onchip_reference_off)
        else $error("reference off survived application reset");
    span_keep_a: assert property (i_app_reset && !i_write |=> $stable(o_span_code))
        else $error("span code changed on application reset");
    code_ok_a: assert property (o_span_code_valid == (o_span_code <= 4'h4 || (o_span_code >= 4'h8 && o_span_code <= 4'hb)))
        else $error("span code validity wrong");
    bit_hold_a: assert property (o_bit_valid && !i_bit_ready |=> o_bit_valid && $stable(o_serial_out) && $stable(o_frame_last))
        else $error("serial bit changed while stalled");
    frame_gap_a: assert property (o_bit_valid && i_bit_ready && o_frame_last |=> !o_bit_valid)
        else $error("no idle cycle after frame");
    end_c: cover property (o_bit_valid && i_bit_ready && o_frame_last);
    stall_c: cover property (o_bit_valid && !i_bit_ready);
    app_c: cover property (i_app_reset);
endmodule // aoff_frame_formatter_checker
bind aoff_frame_formatter aoff_frame_formatter_checker chk_i (.i_clock, .i_reset, .i_app_reset, .i_addr, .i_wdata,
    .i_write, .i_read, .o_rdata, .o_bit_valid, .i_bit_ready, .o_serial_out, .o_frame_last, .o_span_code,
    .o_span_code_valid, .o_onchip_reference_off);
`default_nettype wire

//--- test/aoff_host_model.sv
// Host receiver that takes serial frame bits and stores whole frames
`timescale 1ns/1ps
`default_nettype none
module aoff_host_model (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_bit,
    input wire logic i_valid,
    input wire logic i_last,
    input wire logic i_hold,
    input wire logic i_slow,
    output logic o_ready
);
    logic [31:0] acc;
    logic [31:0] n;
    logic [31:0] got [16];
    logic [31:0] len [16];
    logic tgl;
    int cnt;
    // Slow mode takes every other bit, so the sender must hold a stalled bit
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            o_ready <= 1'b0;
            tgl <= 1'b0;
        end else begin
            tgl <= ~tgl;
            o_ready <= ~i_hold & (~i_slow | tgl);
        end
    end
    always @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            acc = 32'h0;
            n = 32'h0;
            cnt = 0;
        end else if (i_valid && o_ready) begin
            acc = {acc[30:0], i_bit};
            n = n + 32'h1;
            if (i_last) begin
                got[cnt] = acc;
                len[cnt] = n;
                cnt++;
                acc = 32'h0;
                n = 32'h0;
            end
        end
    end
endmodule // aoff_host_model
`default_nettype wire

//--- test/aoff_frame_formatter_tb.sv
// Self-checking testbench for the output frame formatter
`timescale 1ns/1ps
`default_nettype none
module aoff_frame_formatter_tb import aoff_pkg::*; ();
    logic i_clock = 0, i_reset = 1, i_app_reset = 0, i_write = 0, i_read = 0, i_sample_valid = 0;
    logic [7:0] i_addr = 0;
    logic [31:0] i_wdata = 0, o_rdata;
    logic [15:0] i_sample = 0;
    logic [3:0] i_device_addr = 4'ha, o_span_code, span = 4'h9;
    logic i_supply_hi = 0, i_supply_lo = 0, i_input_hi = 0, i_input_lo = 0, hold = 0, slow = 0;
    logic i_bit_ready, o_serial_out, o_bit_valid, o_frame_last, o_frame_active, o_sample_ready;
    logic o_span_unipolar, o_span_code_valid, o_onchip_reference_off;
    logic [31:0] ef [16], el [16];
    int mismatches = 0, cmp_count = 0, nexp = 0, chkd = 0;
    aoff_frame_formatter aoff_frame_formatter_i (.i_clock, .i_reset, .i_app_reset, .i_addr, .i_wdata, .i_write,
        .i_read, .o_rdata, .i_sample, .i_sample_valid, .o_sample_ready, .i_device_addr, .i_supply_hi, .i_supply_lo,
        .i_input_hi, .i_input_lo, .o_serial_out, .o_bit_valid, .i_bit_ready, .o_frame_last, .o_frame_active,
        .o_span_code, .o_span_unipolar, .o_span_code_valid, .o_onchip_reference_off);
    aoff_host_model aoff_host_model_i (.i_clock, .i_reset, .i_bit(o_serial_out), .i_valid(o_bit_valid),
        .i_last(o_frame_last), .i_hold(hold), .i_slow(slow), .o_ready(i_bit_ready));
    initial forever #20 i_clock = ~i_clock;
    task give_verdict;
        if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_write <= 1'b1;
        @(posedge i_clock);
        i_write <= 1'b0;
        @(posedge i_clock);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        i_addr <= a;
        i_read <= 1'b1;
        @(posedge i_clock);
        i_read <= 1'b0;
        @(negedge i_clock);
        chk(o_rdata, e);
        @(posedge i_clock);
    endtask
    function automatic void put(inout logic [31:0] f, inout logic [31:0] n, input logic b);
        f = {f[30:0], b};
        n = n + 32'h1;
    endfunction
    // Expected frame, right aligned, built from the field rules
    function automatic void expf(input logic [31:0] c, input logic [15:0] s, output logic [31:0] f,
        output logic [31:0] n);
        logic [15:0] v;
        logic p;
        v = c[2] ? (c[1] ? (c[0] ? 16'h3333 : 16'h5555) : {16{c[0]}}) : s;
        f = {16'h0, v};
        n = 32'd16;
        p = ^v;
        if (c[14]) for (int i = 3; i >= 0; i--) put(f, n, i_device_addr[i]);
        if (c[12]) put(f, n, i_supply_hi);
        if (c[13]) put(f, n, i_supply_lo);
        if (c[10]) put(f, n, i_input_hi);
        if (c[11]) put(f, n, i_input_lo);
        if (c[8]) for (int i = 3; i >= 0; i--) put(f, n, span[i]);
        if (c[3]) begin
            put(f, n, p);
            put(f, n, ^f[31:1]);
        end
    endfunction
    task send(input logic [31:0] c, input logic [15:0] s);
        logic r;
        expf(c, s, ef[nexp], el[nexp]);
        nexp++;
        i_sample <= s;
        i_sample_valid <= 1'b1;
        for (int t = 0; t < 200; t++) begin
            @(negedge i_clock);
            r = o_sample_ready;
            @(posedge i_clock);
            if (r) break;
        end
        if (r !== 1'b1) begin
            mismatches++;
            $display("ERROR %0t sample never accepted", $time);
        end
        i_sample_valid <= 1'b0;
        @(posedge i_clock);
    endtask
    task wait_frames;
        for (int t = 0; t < 3000 && aoff_host_model_i.cnt < nexp; t++) @(posedge i_clock);
        if (aoff_host_model_i.cnt < nexp) begin
            mismatches++;
            $display("ERROR %0t frames not received in time", $time);
        end
        for (int k = chkd; k < nexp; k++) begin
            chk(aoff_host_model_i.got[k], ef[k]);
            chk(aoff_host_model_i.len[k], el[k]);
        end
        chkd = nexp;
    endtask
    task t_regs;
        rd(8'h10, 32'h0);
        rd(8'h14, 32'h0);
        wr(8'h10, 32'hffffffff);
        rd(8'h10, 32'h00007d0f);
        wr(8'h14, 32'hffffffff);
        rd(8'h14, 32'h0000004f);
        wr(8'h40, 32'hffffffff);
        rd(8'h40, 32'h0);
        for (logic [4:0] c = 0; c < 16; c++) begin
            wr(8'h14, {28'h0, c[3:0]});
            chk({30'h0, o_span_unipolar, o_span_code_valid}, {30'h0, c[3], c <= 4 || (c >= 8 && c <= 11)});
        end
    endtask
    task t_app;
        wr(8'h14, 32'h49);
        chk({31'h0, o_onchip_reference_off}, 32'h1);
        wr(8'h10, 32'h0108);
        i_app_reset <= 1'b1;
        @(posedge i_clock);
        i_app_reset <= 1'b0;
        @(posedge i_clock);
        rd(8'h10, 32'h0);
        rd(8'h14, 32'h9);
    endtask
    task t_frames;
        logic [31:0] cf [8];
        cf = '{32'h0001, 32'h7d08, 32'h180a, 32'h210b, 32'h2104, 32'h250d, 32'h610e, 32'h3d0f};
        i_supply_hi <= 1'b1;
        i_input_lo <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            slow <= k[0];
            if (k == 4) i_supply_lo <= 1'b1;
            wr(8'h10, cf[k]);
            send(cf[k], 16'ha5c3 ^ 16'(k * 4369));
            wait_frames;
        end
    endtask
    // Host stalls while three frames go in: one in the shifter, two buffered
    task t_fill;
        wr(8'h10, 32'h0108);
        hold <= 1'b1;
        slow <= 1'b0;
        @(posedge i_clock);
        for (int k = 0; k < 3; k++) send(32'h0108, 16'h0f00 + 16'(k));
        @(negedge i_clock);
        chk({31'h0, o_sample_ready}, 32'h0);
        chk({31'h0, o_frame_active}, 32'h1);
        @(posedge i_clock);
        rd(8'h18, 32'h5);
        hold <= 1'b0;
        wait_frames;
        chk({31'h0, o_sample_ready}, 32'h1);
        rd(8'h18, 32'h0);
        chk({31'h0, o_frame_active}, 32'h0);
    endtask
    initial begin
        repeat (3) @(posedge i_clock);
        i_reset <= 1'b0;
        @(posedge i_clock);
        t_regs;
        t_app;
        t_frames;
        t_fill;
        give_verdict;
    end
    initial begin
        #400000;
        mismatches++;
        give_verdict;
    end
endmodule // aoff_frame_formatter_tb
`default_nettype wire
